//--- hdl/timer_period_buffer_modes.sv
`timescale 1ns/10ps
`default_nettype none

// What this block does
// (R1) Low byte write goes to staging buffer
// (R2) High byte write commits both bytes together
// (R3) Software writes low byte before high
// (R4) Double buffer enable bit selects buffering
// (R5) Running buffered: swap period at match
// (R6) Buffered reads return double buffer value
// (R7) Stopped buffered write updates both copies
// (R8) Unbuffered write updates period immediately
// (R9) Period below count waits for wrap
// (R10) Code 100 selects external trigger mode
// (R11) Edge bit: 0 rising, 1 falling
// (R12) Trigger waits edge, then counts, clears
// (R13) Retrigger: opposite edge stops and clears
// (R14) No retrigger: edges ignored until run cleared
// (R15) Clearing run stops and zeroes counter
// (R16) Mode and irq enable locked while running
// (R17) Code 010 counts pin edges
// (R18) Events at most half clock rate
// (R19) Code 101 counts while window level
// (R20) Window level: 0 high, 1 low
// (R21) Window match raises irq, clears counter
// (R22) Window much slower than source clock
// (R23) Run bit starts 16-bit up counter
// (R24) Input pin synchronised before detection
module timer_period_buffer_modes
   import timer_pkg::*;
(
   input  wire logic        pclk,            // Bus clock, 50 MHz
   input  wire logic        presetn,         // Async reset, active low
   input  wire logic        psel,            // APB select
   input  wire logic        penable,         // APB access phase
   input  wire logic        pwrite,          // APB write
   input  wire logic [7:0]  paddr,           // APB byte address
   input  wire logic [31:0] pwdata,          // APB write data
   output logic      [31:0] prdata,          // APB read data
   output logic             pready,          // APB ready
   output logic             pslverr,         // APB error
   input  wire logic        timer_input_pin, // External trigger, event or window
   output logic             timer_irq        // One-cycle match pulse
);

   // Register state
   logic            run_bit;                 // Timer running
   logic            double_buffer_enable;    // Double buffering on
   logic            overflow_irq_enable;     // Kept for software, no overflow here
   mode_reg_t       mode;                    // Mode register
   logic [7:0]      staging_low;             // Low byte staging buffer
   logic [15:0]     dbuf;                    // Double buffer
   logic [15:0]     period_register;         // Active compare value
   logic [15:0]     count;                   // Up counter
   logic            match_flag;              // Sticky match flag
   run_state_t      state;                   // Trigger sequencing
   logic [9:0]      prescale;                // Source clock divider
   logic [1:0]      pin_sync;                // Pin synchroniser
   logic            pin_prev;                // Previous synchronised level
   logic            pin_now;                 // Synchronised level

   // Bus decode, pin edges and counter control
   logic            wr_en;                   // Write takes effect
   logic            rd_en;                   // Read takes effect
   logic            mapped;                  // Address decodes
   logic            sel_edge;                // Selected pin edge
   logic            opp_edge;                // Opposite pin edge
   logic            tick;                    // Source clock tick
   logic            window_on;               // Window level present
   logic            step;                    // Counter advances
   logic            hit;                     // Count equals period
   logic            commit;                  // High byte write
   logic [15:0]     new_period;              // Committed value

   // Address check, used only by the error response
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == ADDR_CONTROL) || (a == ADDR_MODE) || (a == ADDR_PER_LOW) ||
                  (a == ADDR_PER_HIGH) || (a == ADDR_COUNT) || (a == ADDR_STATUS);
   endfunction

   assign mapped     = is_mapped(paddr);
   assign wr_en      = psel && penable && pwrite && pready;
   assign rd_en      = psel && penable && !pwrite && pready;
   assign commit     = wr_en && (paddr == ADDR_PER_HIGH);
   assign new_period = {pwdata[7:0], staging_low};       // R2

   // Pin synchroniser, first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_sync <= 2'h0;
         pin_prev <= 1'b0;
      end else begin
         pin_sync <= {pin_sync[0], timer_input_pin}; // R24
         pin_prev <= pin_sync[1];
      end
   end
   assign pin_now  = pin_sync[1];

   // Edge select: 0 rising, 1 falling
   assign sel_edge = mode.edge_level_select ? (pin_prev && !pin_now)
                                            : (!pin_prev && pin_now); // R11
   assign opp_edge = mode.edge_level_select ? (!pin_prev && pin_now)
                                            : (pin_prev && !pin_now);
   assign window_on = mode.edge_level_select ? !pin_now : pin_now; // R20

   // Source clock divider, tap chosen by clock select
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale <= 10'h000;
      end else if (!run_bit) begin
         prescale <= 10'h000;
      end else begin
         prescale <= prescale + 10'h001;
      end
   end
   always_comb begin
      case (mode.source_clock_select)
         2'h0:    tick = (prescale == PRESCALE_MAX);
         2'h1:    tick = (prescale[5:0] == PRESCALE_MAX[5:0]);
         2'h2:    tick = (prescale[1:0] == PRESCALE_MAX[1:0]);
         default: tick = prescale[0];
      endcase
   end

   // Counter advance per mode
   always_comb begin
      case (mode.mode_select)
         MODE_TRIGGER: step = (state == ST_COUNT) && tick;   // R10
         MODE_EVENT:   step = sel_edge;                      // R17
         MODE_WINDOW:  step = window_on && tick;             // R19
         default:      step = 1'b0;
      endcase
   end

   // Match only on equality, so a smaller period waits for the wrap
   assign hit = run_bit && step && (count == period_register); // R9

   // Trigger sequencing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
      end else if (!run_bit) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE:  state <= ST_ARMED;
            ST_ARMED: begin
               if (sel_edge) begin
                  state <= ST_COUNT;                         // R12
               end
            end
            ST_COUNT: begin
               // Without retrigger, neither edge is watched here
               if (mode.retrigger_enable && opp_edge) begin  // R14
                  state <= ST_ARMED;                         // R13
               end
            end
            default:  state <= ST_IDLE;
         endcase
      end
   end

   // Up counter; a match counts as the step that clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= COUNT_ZERO;
      end else if (!run_bit) begin
         count <= COUNT_ZERO;                                // R15
      end else if (mode.mode_select == MODE_TRIGGER && state == ST_COUNT &&
                   mode.retrigger_enable && opp_edge) begin
         count <= COUNT_ZERO;                                // R13
      end else if (hit) begin
         count <= COUNT_ZERO;                                // R12 R21
      end else if (step) begin
         count <= count + 16'h0001;                          // R23
      end
   end

   // Interrupt pulse on every match
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_irq <= 1'b0;
      end else begin
         timer_irq <= hit;                                   // R21
      end
   end

   // Sticky flag, set beats clear on read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_flag <= 1'b0;
      end else if (hit) begin
         match_flag <= 1'b1;
      end else if (rd_en && paddr == ADDR_STATUS) begin
         match_flag <= 1'b0;
      end
   end

   // Control register; overflow irq enable locked while running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_bit              <= 1'b0;
         double_buffer_enable <= 1'b0;
         overflow_irq_enable  <= 1'b0;
      end else if (wr_en && paddr == ADDR_CONTROL) begin
         run_bit              <= pwdata[CTL_RUN];
         double_buffer_enable <= pwdata[CTL_DBUF];           // R4
         if (!run_bit) begin
            overflow_irq_enable <= pwdata[CTL_OVIE];         // R16
         end
      end
   end

   // Mode register, ignored while running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode <= MODE_RESET;
      end else if (wr_en && paddr == ADDR_MODE && !run_bit) begin
         mode <= mode_reg_t'(pwdata[7:0]);                  // R16
      end
   end

   // Low byte staging buffer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         staging_low <= LOW_RESET;
      end else if (wr_en && paddr == ADDR_PER_LOW) begin
         staging_low <= pwdata[7:0];                         // R1
      end
   end

   // Double buffer takes every commit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dbuf <= PERIOD_RESET;
      end else if (commit) begin
         dbuf <= new_period;                                 // R2
      end
   end

   // Active period update
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_register <= PERIOD_RESET;
      end else if (commit && (!double_buffer_enable || !run_bit)) begin
         period_register <= new_period;                      // R7 R8
      end else if (double_buffer_enable && hit) begin
         period_register <= dbuf;                            // R5
      end
   end

   // Read data and answer, zero wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            ADDR_CONTROL:  prdata <= {29'h0, overflow_irq_enable,
                                      double_buffer_enable, run_bit};
            ADDR_MODE:     prdata <= {24'h0, mode};
            ADDR_PER_LOW:  prdata <= {24'h0, double_buffer_enable ? dbuf[7:0]
                                                  : period_register[7:0]};  // R6
            ADDR_PER_HIGH: prdata <= {24'h0, double_buffer_enable ? dbuf[15:8]
                                                  : period_register[15:8]}; // R6
            ADDR_COUNT:    prdata <= {16'h0, count};
            ADDR_STATUS:   prdata <= {31'h0, match_flag};
            default:       prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Ready in access phase, error on unmapped address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
      end
   end

   // Checks
   property p_stop_clears;
      @(posedge pclk) disable iff (!presetn)
      !run_bit |=> (count == COUNT_ZERO);
   endproperty
   a_stop_clears: assert property (p_stop_clears) else $error("count not zero when stopped"); // R15

   property p_match_irq;
      @(posedge pclk) disable iff (!presetn)
      hit |=> timer_irq && (count == COUNT_ZERO);
   endproperty
   a_match_irq: assert property (p_match_irq) else $error("match did not pulse irq"); // R12

   property p_stage;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == ADDR_PER_LOW) |=> staging_low == $past(pwdata[7:0]);
   endproperty
   a_stage: assert property (p_stage) else $error("low byte not staged"); // R1

   property p_commit;
      @(posedge pclk) disable iff (!presetn)
      commit |=> dbuf == $past(new_period);
   endproperty
   a_commit: assert property (p_commit) else $error("commit lost"); // R2

   property p_nobuf;
      @(posedge pclk) disable iff (!presetn)
      (commit && !double_buffer_enable) |=> period_register == $past(new_period);
   endproperty
   a_nobuf: assert property (p_nobuf) else $error("unbuffered write not applied"); // R8

   property p_buf_hold;
      @(posedge pclk) disable iff (!presetn)
      (commit && double_buffer_enable && run_bit && !hit) |=> $stable(period_register);
   endproperty
   a_buf_hold: assert property (p_buf_hold) else $error("buffered write applied early"); // R5

   property p_mode_lock;
      @(posedge pclk) disable iff (!presetn)
      run_bit && $past(run_bit) |-> $stable(mode);
   endproperty
   a_mode_lock: assert property (p_mode_lock) else $error("mode changed while running"); // R16

   sequence s_armed;
      run_bit && state == ST_ARMED && mode.mode_select == MODE_TRIGGER;
   endsequence
   property p_armed_idle;
      @(posedge pclk) disable iff (!presetn)
      s_armed ##1 (run_bit && state == ST_ARMED) |-> $stable(count);
   endproperty
   a_armed_idle: assert property (p_armed_idle) else $error("count moved before trigger"); // R12

   property p_no_retrig;
      @(posedge pclk) disable iff (!presetn)
      (run_bit && state == ST_COUNT && !mode.retrigger_enable) |=> state == ST_COUNT;
   endproperty
   a_no_retrig: assert property (p_no_retrig) else $error("edge acted without retrigger"); // R14

   property p_window;
      @(posedge pclk) disable iff (!presetn)
      (mode.mode_select == MODE_WINDOW && !window_on && run_bit) |=> $stable(count) || count == COUNT_ZERO;
   endproperty
   a_window: assert property (p_window) else $error("counted outside window"); // R19
endmodule

`default_nettype wire

//--- shared/timer_pkg.sv
package timer_pkg;
   // Register byte offsets (each register one aligned word)
   localparam logic [7:0] ADDR_CONTROL  = 8'h00;   // run, double buffer, overflow irq enable
   localparam logic [7:0] ADDR_MODE     = 8'h04;   // mode, clock select, edge, retrigger
   localparam logic [7:0] ADDR_PER_LOW  = 8'h08;   // period low byte
   localparam logic [7:0] ADDR_PER_HIGH = 8'h0C;   // period high byte
   localparam logic [7:0] ADDR_COUNT    = 8'h10;   // live counter, read only
   localparam logic [7:0] ADDR_STATUS   = 8'h14;   // match event flag, clear on read

   // Control field positions
   localparam int CTL_RUN  = 0;
   localparam int CTL_DBUF = 1;
   localparam int CTL_OVIE = 2;

   // Reset values
   localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
   localparam logic [15:0] COUNT_ZERO   = 16'h0000;
   localparam logic [7:0]  LOW_RESET    = 8'hFF;

   // Mode codes
   localparam logic [2:0] MODE_TRIGGER = 3'h4;
   localparam logic [2:0] MODE_EVENT   = 3'h2;
   localparam logic [2:0] MODE_WINDOW  = 3'h5;

   // Source clock prescale taps, index by source clock select
   localparam logic [9:0] PRESCALE_MAX = 10'h3FF;

   // Mode register fields packed together
   typedef struct packed {
      logic       retrigger_enable;   // bit 7
      logic       edge_level_select;  // bit 6
      logic [1:0] source_clock_select;// bits 5:4
      logic       unused;             // bit 3
      logic [2:0] mode_select;        // bits 2:0
   } mode_reg_t;

   localparam mode_reg_t MODE_RESET = '0;

   // Trigger state machine
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ARMED,
      ST_COUNT
   } run_state_t;
endpackage

//--- dv/pulse_source.sv
`timescale 1ns/10ps
`default_nettype none

// Model of the pulse source on the timer input pin
module pulse_source (
   input  wire logic pclk,   // Machine clock
   output logic      pin     // Driven input pin level
);
   // Pin idles low until a scenario moves it
   initial begin
      pin = 1'b0;
   end

   // Full pulses, three cycles high and four low, then settle time
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge pclk);
         pin <= 1'b1;
         repeat (3) @(posedge pclk);
         pin <= 1'b0;
         repeat (3) @(posedge pclk);
      end
      repeat (4) @(posedge pclk);
   endtask

   // Slow level change for trigger and window use
   task automatic level(input logic v);
      @(posedge pclk);
      pin <= v;
      repeat (4) @(posedge pclk);
   endtask
endmodule

`default_nettype wire

//--- dv/tb_timer_period_buffer_modes.sv
`timescale 1ns/10ps
`default_nettype none

module tb_timer_period_buffer_modes
   import timer_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite; // Bus controls
   logic        pready, pslverr, timer_irq, pin;      // Design outputs and pin
   logic [7:0]  paddr;                                // Byte address
   logic [31:0] pwdata, prdata, rv;                   // Data and last read
   logic        rerr;                                 // Last error flag
   int          num_errors = 0;                       // Mismatch count
   int          total_checks = 0;                     // Comparison count
   int          irq_n = 0;                            // Match pulses seen
   int          base;                                 // Pulse count mark

   timer_period_buffer_modes u_dut (
      .pclk            (pclk),
      .presetn         (presetn),
      .psel            (psel),
      .penable         (penable),
      .pwrite          (pwrite),
      .paddr           (paddr),
      .pwdata          (pwdata),
      .prdata          (prdata),
      .pready          (pready),
      .pslverr         (pslverr),
      .timer_input_pin (pin),
      .timer_irq       (timer_irq)
   );

   pulse_source u_src (.pclk(pclk), .pin(pin));

   // 50 MHz clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // Tally match pulses
   always @(posedge pclk) begin
      if (timer_irq === 1'b1) begin
         irq_n <= irq_n + 1;
      end
   end

   // Verdict and end of run
   task automatic close_out();
      if (num_errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Compare and report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rv   = prdata;
      rerr = pslverr;
      if (n >= 50) begin
         num_errors++;
         $display("MISMATCH %0t bus hang", $time);
         close_out();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Register write
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   // Register read into rv
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0000_0000);
   endtask

   // Period write, low byte staged first
   task automatic per(input logic [15:0] p);
      wr(ADDR_PER_LOW, 32'(p[7:0]));
      wr(ADDR_PER_HIGH, 32'(p[15:8]));
   endtask

   // Mode register value
   function automatic logic [31:0] mv(input logic r, input logic e,
                                      input logic [1:0] ck, input logic [2:0] md);
      mv = {24'h00_0000, r, e, ck, 1'b0, md};
   endfunction

   // Watchdog
   initial begin
      repeat (100000) @(posedge pclk);
      num_errors++;
      $display("MISMATCH %0t run timed out", $time);
      close_out();
   end

   // Main sequence
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0000_0000;
      presetn = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values and unmapped access
      rd(ADDR_PER_HIGH);
      chk(32'(rv[7:0]), 32'h0000_00FF);
      rd(ADDR_COUNT);
      chk(32'(rv[15:0]), 32'h0000_0000);
      chk(32'(rerr), 32'h0000_0000);
      rd(8'h18);
      chk(32'(rerr), 32'h0000_0001);
      // Event counting on each edge polarity, lock while running
      for (int e = 0; e < 2; e++) begin
         wr(ADDR_MODE, mv(1'b0, e[0], 2'h0, MODE_EVENT));
         per(16'h0003);
         wr(ADDR_CONTROL, 32'h0000_0001);
         base = irq_n;
         u_src.pulses(5);
         rd(ADDR_COUNT);
         chk(32'(rv[15:0]), 32'h0000_0001);
         chk(32'(irq_n - base), 32'h0000_0001);
         rd(ADDR_STATUS);
         chk(32'(rv[0]), 32'h0000_0001);
         rd(ADDR_STATUS);
         chk(32'(rv[0]), 32'h0000_0000);
         wr(ADDR_MODE, mv(1'b0, 1'b0, 2'h0, MODE_WINDOW));
         wr(ADDR_CONTROL, 32'h0000_0005);
         rd(ADDR_MODE);
         chk(32'(rv[7:0]), mv(1'b0, e[0], 2'h0, MODE_EVENT));
         rd(ADDR_CONTROL);
         chk(32'(rv[2:0]), 32'h0000_0001);
         wr(ADDR_CONTROL, 32'h0000_0000);
         rd(ADDR_COUNT);
         chk(32'(rv[15:0]), 32'h0000_0000);
      end
      // Double buffered period swap at match
      wr(ADDR_MODE, mv(1'b0, 1'b0, 2'h0, MODE_EVENT));
      wr(ADDR_CONTROL, 32'h0000_0002);
      per(16'h0005);
      wr(ADDR_CONTROL, 32'h0000_0003);
      base = irq_n;
      u_src.pulses(2);
      per(16'h0003);
      rd(ADDR_PER_LOW);
      chk(32'(rv[7:0]), 32'h0000_0003);
      u_src.pulses(1);
      chk(32'(irq_n - base), 32'h0000_0000);
      u_src.pulses(7);
      chk(32'(irq_n - base), 32'h0000_0002);
      // Unbuffered: period below count waits for wrap
      wr(ADDR_CONTROL, 32'h0000_0000);
      wr(ADDR_CONTROL, 32'h0000_0001);
      base = irq_n;
      u_src.pulses(2);
      per(16'h0001);
      u_src.pulses(2);
      chk(32'(irq_n - base), 32'h0000_0000);
      rd(ADDR_COUNT);
      chk(32'(rv[15:0]), 32'h0000_0004);
      wr(ADDR_CONTROL, 32'h0000_0000);
      wr(ADDR_CONTROL, 32'h0000_0001);
      per(16'h0002);
      base = irq_n;
      u_src.pulses(3);
      chk(32'(irq_n - base), 32'h0000_0001);
      // Trigger mode with retrigger
      wr(ADDR_CONTROL, 32'h0000_0000);
      wr(ADDR_MODE, mv(1'b1, 1'b0, 2'h3, MODE_TRIGGER));
      per(16'hFFFF);
      wr(ADDR_CONTROL, 32'h0000_0001);
      repeat (20) @(posedge pclk);
      rd(ADDR_COUNT);
      chk(32'(rv[15:0]), 32'h0000_0000);
      u_src.level(1'b1);
      repeat (20) @(posedge pclk);
      rd(ADDR_COUNT);
      chk(32'(rv[15:0] != 16'h0000), 32'h0000_0001);
      u_src.level(1'b0);
      repeat (20) @(posedge pclk);
      rd(ADDR_COUNT);
      chk(32'(rv[15:0]), 32'h0000_0000);
      // Trigger mode without retrigger
      wr(ADDR_CONTROL, 32'h0000_0000);
      wr(ADDR_MODE, mv(1'b0, 1'b0, 2'h3, MODE_TRIGGER));
      per(16'h0014);
      wr(ADDR_CONTROL, 32'h0000_0001);
      base = irq_n;
      u_src.level(1'b1);
      u_src.level(1'b0);
      rd(ADDR_COUNT);
      chk(32'(rv[15:0] != 16'h0000), 32'h0000_0001);
      repeat (100) @(posedge pclk);
      chk(32'(irq_n > base), 32'h0000_0001);
      // Window mode, both levels
      for (int w = 0; w < 2; w++) begin
         wr(ADDR_CONTROL, 32'h0000_0000);
         wr(ADDR_MODE, mv(1'b0, w[0], {1'b1, w[0]}, MODE_WINDOW));
         per(16'h0004);
         u_src.level(w[0]);
         wr(ADDR_CONTROL, 32'h0000_0001);
         repeat (20) @(posedge pclk);
         rd(ADDR_COUNT);
         chk(32'(rv[15:0]), 32'h0000_0000);
         base = irq_n;
         u_src.level(~w[0]);
         repeat (40) @(posedge pclk);
         chk(32'(irq_n > base), 32'h0000_0001);
      end
      close_out();
   end
endmodule

`default_nettype wire
